// [hdl/tsa_consts.svh]
// Purpose: shared constants of the temperature sensor alarm block
// Assumes: included by bare name, definitions only
// Notes:   times are kept in their own unit and turned into cycles here
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// clock and timing
`define TSA_CLK_PERIOD_NS   8
`define TSA_CLK_KHZ         125000
`define TSA_CONV_TIME_MS    130
`define TSA_CONV_CYC        (`TSA_CONV_TIME_MS * `TSA_CLK_KHZ)
`define TSA_SPIKE_NS        50
`define TSA_SPIKE_CYC       ((`TSA_SPIKE_NS + `TSA_CLK_PERIOD_NS - 1) / `TSA_CLK_PERIOD_NS)

// reset values
`define TSA_TEMP_RESET      16'h8000
`define TSA_HIGH_LIMIT_THRESHOLD_RESET     16'h5000
`define TSA_LOW_LIMIT_THRESHOLD_RESET      16'h4B00
`define TSA_CFG_RESET       8'h00
`define TSA_CFG_WMASK       8'h1F

// configuration fields
`define TSA_CFG_SHDN        0
`define TSA_CFG_INTM        1
`define TSA_CFG_POL         2
`define TSA_CFG_FQ_LO       3
`define TSA_CFG_FQ_HI       4

// pointer selections
`define TSA_PTR_TEMP        2'h0
`define TSA_PTR_CFG         2'h1
`define TSA_PTR_LOW_LIMIT_THRESHOLD        2'h2
`define TSA_PTR_HIGH_LIMIT_THRESHOLD       2'h3

// upper five bits of the seven-bit serial address
`define TSA_I2C_BASE        5'h12

// software register map, byte addresses
`define TSA_AXI_IRQ_STATUS  8'h00
`define TSA_AXI_IRQ_MASK    8'h04
`define TSA_AXI_STATE       8'h08
`define TSA_IRQ_CONV        0
`define TSA_IRQ_ALARM       1
`define TSA_IRQ_WRITE       2
`define TSA_AXI_OKAY        2'h0
`define TSA_AXI_DECERR      2'h3

`endif

// [hdl/tsa_pkg.sv]
// Purpose: types of the temperature sensor alarm block
// Assumes: used by scoped name only
// Notes:   serial slave states follow a gray path
package tsa_pkg;
  typedef enum logic [2:0] {
    TSA_S_IDLE = 3'h0,
    TSA_S_ADDR = 3'h1,
    TSA_S_AACK = 3'h3,
    TSA_S_RX   = 3'h2,
    TSA_S_RACK = 3'h6,
    TSA_S_TX   = 3'h7,
    TSA_S_TACK = 3'h5,
    TSA_S_WAIT = 3'h4
  } tsa_i2c_state_e;
endpackage : tsa_pkg

// [hdl/tsa_top.sv]
// Purpose: digital side of a temperature sensor with serial slave and alarm
// Assumes: adc_code is the converter output on mclk; serial pins are asynchronous
// Notes:   software sees irq status, mask and a state word over AXI4-Lite
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tsa_consts.svh"

module tsa_top #(
  parameter int          CONV_CYC = `TSA_CONV_CYC,
  parameter int          RES_BITS = 12,
  parameter int unsigned AW       = 8
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output wire logic          sda_out,
  output wire logic          sda_oe,
  input  wire logic          add_in,
  input  wire logic [15:0]   adc_code,
  output wire logic          overtemp_alarm_out,
  output wire logic          irq,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output wire logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output wire logic          s_axi_wready,
  output wire logic [1:0]    s_axi_bresp,
  output wire logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output wire logic          s_axi_arready,
  output wire logic [31:0]   s_axi_rdata,
  output wire logic [1:0]    s_axi_rresp,
  output wire logic          s_axi_rvalid,
  input  wire logic          s_axi_rready
);

  localparam logic [15:0] RES_MASK = 16'(16'hFFFF << (16 - RES_BITS));
  localparam logic [31:0] CONV_LAST = 32'(CONV_CYC - 1);
  localparam logic [2:0]  SPK_LAST = 3'(`TSA_SPIKE_CYC - 1);

  wire  logic [2:0] pin_raw;
  logic [2:0]       pin_f;
  assign pin_raw = {add_in, sda_in, scl_in};

  // two-stage sync then a stability filter per pin, glitches never reach the fsm
  for (genvar i = 0; i < 3; i++)
  begin : g_pin
    logic       s1_r, s2_r, f_r, f_nxt;
    logic [2:0] c_r, c_nxt;
    always_comb
    begin
      f_nxt = f_r;
      c_nxt = 3'h0;
      if (s2_r != f_r)
      begin
        c_nxt = c_r + 3'h1;
        if (c_r == SPK_LAST)
        begin
          f_nxt = s2_r;
          c_nxt = 3'h0;
        end
      end
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        f_r  <= 1'b1;
        c_r  <= 3'h0;
      end
      else
      begin
        s1_r <= pin_raw[i];
        s2_r <= s1_r;
        f_r  <= f_nxt;
        c_r  <= c_nxt;
      end
    end
    assign pin_f[i] = f_r;
  end

  wire logic scl_f = pin_f[0];
  wire logic sda_f = pin_f[1];
  wire logic add_f = pin_f[2];

  tsa_pkg::tsa_i2c_state_e st_r, st_nxt;
  logic        scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt, msb_r, msb_nxt, txsh_r, txsh_nxt, cfg_r, cfg_nxt;
  logic        rw_r, rw_nxt, txb_r, txb_nxt, nack_r, nack_nxt, hold_r, hold_nxt;
  logic [1:0]  byte_r, byte_nxt, ptr_r, ptr_nxt, sel;
  logic [15:0] txw_r, txw_nxt, high_limit_threshold_r, high_limit_threshold_nxt, low_limit_threshold_r, low_limit_threshold_nxt;
  logic [15:0] temp_r, temp_nxt, rd_word;
  logic [31:0] conv_r, conv_nxt;
  logic        alarm_r, alarm_nxt, hi_r, hi_nxt, lo_r, lo_nxt, dsda_r, dsda_nxt;
  logic [2:0]  fault_r, fault_nxt, depth, ev;
  logic        scl_rise, scl_fall, start, stop, rd_evt, wr_evt, conv_done, cond;

  // address pin: tracks sda or scl, stuck high or stuck low, sampled inside transfers from the first start on
  always_comb
  begin
    if (!hi_r)
      sel = 2'h0;
    else if (!lo_r)
      sel = 2'h1;
    else if (!dsda_r)
      sel = 2'h2;
    else
      sel = 2'h3;
  end

  // word offered on the pins is taken from the pointer at address time
  always_comb
  begin
    case (ptr_r)
      `TSA_PTR_TEMP:  rd_word = temp_r;
      `TSA_PTR_CFG:   rd_word = {cfg_r, cfg_r};
      `TSA_PTR_LOW_LIMIT_THRESHOLD:  rd_word = low_limit_threshold_r;
      default:        rd_word = high_limit_threshold_r;
    endcase
  end

  always_comb
  begin
    case (cfg_r[`TSA_CFG_FQ_HI:`TSA_CFG_FQ_LO])
      2'h0:    depth = 3'h1;
      2'h1:    depth = 3'h2;
      2'h2:    depth = 3'h4;
      default: depth = 3'h6;
    endcase
  end

  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start    = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop     = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // serial slave, conversion timer and alarm share one next-state process
  always_comb
  begin
    st_nxt = st_r;     bit_nxt = bit_r;     sh_nxt = sh_r;     rw_nxt = rw_r;
    byte_nxt = byte_r; ptr_nxt = ptr_r;     msb_nxt = msb_r;   txw_nxt = txw_r;
    txsh_nxt = txsh_r; txb_nxt = txb_r;     nack_nxt = nack_r; cfg_nxt = cfg_r;
    high_limit_threshold_nxt = high_limit_threshold_r; low_limit_threshold_nxt = low_limit_threshold_r; hold_nxt = hold_r;
    scl_d_nxt = scl_f; sda_d_nxt = sda_f;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    dsda_nxt = dsda_r;
    // strap watched only inside a transfer: the filters reset high and would fake a level
    if (st_r != tsa_pkg::TSA_S_IDLE)
    begin
      hi_nxt = hi_r | add_f;
      lo_nxt = lo_r | ~add_f;
      dsda_nxt = dsda_r | (add_f ^ sda_f);
    end
    rd_evt = 1'b0;
    wr_evt = 1'b0;
    if (stop)
    begin
      st_nxt = tsa_pkg::TSA_S_IDLE;
      hold_nxt = 1'b0;
    end
    else if (start)
    begin
      st_nxt = tsa_pkg::TSA_S_ADDR;
      bit_nxt = 4'h0;
      byte_nxt = 2'h0;
    end
    else if (scl_rise)
    begin
      if (st_r == tsa_pkg::TSA_S_ADDR || st_r == tsa_pkg::TSA_S_RX)
      begin
        sh_nxt = {sh_r[6:0], sda_f};
        bit_nxt = bit_r + 4'h1;
      end
      else if (st_r == tsa_pkg::TSA_S_TACK)
        nack_nxt = sda_f;
    end
    else if (scl_fall)
    begin
      case (st_r)
        tsa_pkg::TSA_S_ADDR:
          if (bit_r == 4'h8)
          begin
            if (sh_r[7:1] == {`TSA_I2C_BASE, sel})
            begin
              st_nxt = tsa_pkg::TSA_S_AACK;
              rw_nxt = sh_r[0];
              rd_evt = sh_r[0];
              txw_nxt = rd_word;
              if (sh_r[0] && ptr_r == `TSA_PTR_TEMP)
                hold_nxt = 1'b1;
            end
            else
              st_nxt = tsa_pkg::TSA_S_WAIT;
          end
        tsa_pkg::TSA_S_RX:
          if (bit_r == 4'h8)
          begin
            st_nxt = tsa_pkg::TSA_S_RACK;
            if (byte_r != 2'h3)
              byte_nxt = byte_r + 2'h1;
            if (byte_r == 2'h0)
              ptr_nxt = sh_r[1:0];
            else if (byte_r == 2'h1)
            begin
              msb_nxt = sh_r;
              if (ptr_r == `TSA_PTR_CFG)
              begin
                cfg_nxt = sh_r & `TSA_CFG_WMASK;
                wr_evt = 1'b1;
              end
            end
            else if (byte_r == 2'h2 && ptr_r[1])
            begin
              wr_evt = 1'b1;
              if (ptr_r == `TSA_PTR_LOW_LIMIT_THRESHOLD)
                low_limit_threshold_nxt = {msb_r, sh_r[7], 7'h00};
              else
                high_limit_threshold_nxt = {msb_r, sh_r[7], 7'h00};
            end
          end
        tsa_pkg::TSA_S_AACK:
        begin
          bit_nxt = 4'h0;
          st_nxt = rw_r ? tsa_pkg::TSA_S_TX : tsa_pkg::TSA_S_RX;
          txsh_nxt = txw_r[15:8];
          txb_nxt = 1'b1;
        end
        tsa_pkg::TSA_S_RACK:
        begin
          bit_nxt = 4'h0;
          st_nxt = tsa_pkg::TSA_S_RX;
        end
        tsa_pkg::TSA_S_TX:
          if (bit_r == 4'h7)
            st_nxt = tsa_pkg::TSA_S_TACK;
          else
          begin
            txsh_nxt = {txsh_r[6:0], 1'b0};
            bit_nxt = bit_r + 4'h1;
          end
        tsa_pkg::TSA_S_TACK:
          if (nack_r)
            st_nxt = tsa_pkg::TSA_S_WAIT; // master ends the read
          else
          begin
            st_nxt = tsa_pkg::TSA_S_TX;
            bit_nxt = 4'h0;
            txsh_nxt = txb_r ? txw_r[7:0] : txw_r[15:8];
            txb_nxt = ~txb_r;
          end
        default: st_nxt = st_r;
      endcase
    end

    // free running conversion; shutdown and a temperature read restart the interval
    conv_done = 1'b0;
    temp_nxt = temp_r;
    conv_nxt = conv_r + 32'h1;
    if (cfg_r[`TSA_CFG_SHDN])
    begin
      conv_nxt = 32'h0;
      temp_nxt = `TSA_TEMP_RESET;
    end
    else if (hold_r)
      conv_nxt = 32'h0;
    else if (conv_r == CONV_LAST)
    begin
      conv_nxt = 32'h0;
      conv_done = 1'b1;
      temp_nxt = adc_code & RES_MASK;
    end

    // fault queue; a read clear comes first so a same-cycle trip is kept
    alarm_nxt = alarm_r;
    fault_nxt = fault_r;
    if (rd_evt && cfg_r[`TSA_CFG_INTM])
    begin
      alarm_nxt = 1'b0;
      fault_nxt = 3'h0;
    end
    if (!alarm_nxt)
      cond = $signed(temp_nxt) > $signed(high_limit_threshold_r);
    else if (!cfg_r[`TSA_CFG_INTM])
      cond = $signed(temp_nxt) < $signed(low_limit_threshold_r);
    else
      cond = 1'b0;
    if (conv_done)
    begin
      if (!cond)
        fault_nxt = 3'h0;
      else if (fault_nxt + 3'h1 >= depth)
      begin
        alarm_nxt = ~alarm_nxt;
        fault_nxt = 3'h0;
      end
      else
        fault_nxt = fault_nxt + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= tsa_pkg::TSA_S_IDLE;
      scl_d_r <= 1'b1;   sda_d_r <= 1'b1;   bit_r <= 4'h0;     sh_r <= 8'h00;
      rw_r <= 1'b0;      byte_r <= 2'h0;    ptr_r <= `TSA_PTR_TEMP;
      msb_r <= 8'h00;    txw_r <= 16'h0000; txsh_r <= 8'h00;   txb_r <= 1'b0;
      nack_r <= 1'b0;    cfg_r <= `TSA_CFG_RESET;
      high_limit_threshold_r <= `TSA_HIGH_LIMIT_THRESHOLD_RESET;
      low_limit_threshold_r <= `TSA_LOW_LIMIT_THRESHOLD_RESET;
      hold_r <= 1'b0;    conv_r <= 32'h0;
      temp_r <= `TSA_TEMP_RESET;
      alarm_r <= 1'b0;   fault_r <= 3'h0;
      hi_r <= 1'b0;      lo_r <= 1'b0;      dsda_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      scl_d_r <= scl_d_nxt; sda_d_r <= sda_d_nxt; bit_r <= bit_nxt;  sh_r <= sh_nxt;
      rw_r <= rw_nxt;       byte_r <= byte_nxt;   ptr_r <= ptr_nxt;
      msb_r <= msb_nxt;     txw_r <= txw_nxt;     txsh_r <= txsh_nxt; txb_r <= txb_nxt;
      nack_r <= nack_nxt;   cfg_r <= cfg_nxt;
      high_limit_threshold_r <= high_limit_threshold_nxt;
      low_limit_threshold_r <= low_limit_threshold_nxt;
      hold_r <= hold_nxt;   conv_r <= conv_nxt;
      temp_r <= temp_nxt;
      alarm_r <= alarm_nxt; fault_r <= fault_nxt;
      hi_r <= hi_nxt;       lo_r <= lo_nxt;       dsda_r <= dsda_nxt;
    end
  end

  // open drain: only ever pull low, during acks and zero data bits
  assign sda_out = 1'b0;
  assign sda_oe  = (st_r == tsa_pkg::TSA_S_AACK) || (st_r == tsa_pkg::TSA_S_RACK) ||
                   ((st_r == tsa_pkg::TSA_S_TX) && !txsh_r[7]);
  assign overtemp_alarm_out = alarm_r ~^ cfg_r[`TSA_CFG_POL];

  // software side: sticky events, mask, read-to-clear status
  logic          awh_r, awh_nxt, wh_r, wh_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [AW-1:0] awa_r, awa_nxt;
  logic [31:0]   wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]    ws_r, ws_nxt;
  logic [1:0]    br_r, br_nxt, rr_r, rr_nxt;
  logic [2:0]    stat_r, stat_nxt, mask_r, mask_nxt, clr;

  assign ev = {wr_evt, alarm_nxt & ~alarm_r, conv_done};

  always_comb
  begin
    awh_nxt = awh_r; awa_nxt = awa_r; wh_nxt = wh_r; wd_nxt = wd_r; ws_nxt = ws_r;
    bv_nxt = bv_r;   br_nxt = br_r;   rv_nxt = rv_r; rd_nxt = rd_r; rr_nxt = rr_r;
    mask_nxt = mask_r;
    clr = 3'h0;
    if (s_axi_awvalid && !awh_r)
    begin
      awh_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wh_r)
    begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bv_r && s_axi_bready)
      bv_nxt = 1'b0;
    else if (awh_r && wh_r && !bv_r)
    begin
      awh_nxt = 1'b0;
      wh_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = `TSA_AXI_OKAY;
      if (awa_r == `TSA_AXI_IRQ_MASK)
      begin
        if (ws_r[0])
          mask_nxt = wd_r[2:0];
      end
      else if (awa_r != `TSA_AXI_IRQ_STATUS && awa_r != `TSA_AXI_STATE)
        br_nxt = `TSA_AXI_DECERR;
    end
    if (rv_r && s_axi_rready)
      rv_nxt = 1'b0;
    else if (s_axi_arvalid && !rv_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = `TSA_AXI_OKAY;
      case (s_axi_araddr)
        `TSA_AXI_IRQ_STATUS:
        begin
          rd_nxt = {29'h0, stat_r};
          clr = stat_r;
        end
        `TSA_AXI_IRQ_MASK: rd_nxt = {29'h0, mask_r};
        `TSA_AXI_STATE:    rd_nxt = {11'h000, hold_r, sel, cfg_r[`TSA_CFG_SHDN], alarm_r,
                                     temp_r};
        default:
        begin
          rd_nxt = 32'h0;
          rr_nxt = `TSA_AXI_DECERR;
        end
      endcase
    end
    stat_nxt = (stat_r & ~clr) | ev; // set wins over the read clear
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awh_r <= 1'b0;  awa_r <= '0;    wh_r <= 1'b0;  wd_r <= 32'h0; ws_r <= 4'h0;
      bv_r <= 1'b0;   br_r <= 2'h0;   rv_r <= 1'b0;  rd_r <= 32'h0; rr_r <= 2'h0;
      stat_r <= 3'h0; mask_r <= 3'h0;
    end
    else
    begin
      awh_r <= awh_nxt; awa_r <= awa_nxt; wh_r <= wh_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
      bv_r <= bv_nxt;   br_r <= br_nxt;   rv_r <= rv_nxt; rd_r <= rd_nxt; rr_r <= rr_nxt;
      stat_r <= stat_nxt; mask_r <= mask_nxt;
    end
  end

  assign s_axi_awready = ~awh_r;
  assign s_axi_wready  = ~wh_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = ~rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
  assign irq           = |(stat_r & mask_r);

endmodule : tsa_top

// [verification/tsa_props.sv]
// Purpose: port assertions for the sensor alarm block
// Assumes: sees tsa_top ports only, one clock domain
// Notes:   axi figures follow the designer's walk
`timescale 1ns/1ps
module tsa_chk #(
  parameter int unsigned AW = 8
) (
  input wire logic          mclk,
  input wire logic          rst_n,
  input wire logic          sda_out,
  input wire logic          sda_oe,
  input wire logic          overtemp_alarm_out,
  input wire logic          irq,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // write: both halves taken, one quiet edge, then the answer
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_walk:
    assert property (s_wr_take |=> s_wr_answer) else $error("write answer out of step");
  chk_wr_refuse:
    assert property (s_wr_take ##0 s_axi_awaddr >= 8'h0C |=> ##1 s_axi_bresp == 2'h3)
      else $error("unmapped write not refused");
  chk_b_stand:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
  chk_rd_answer:
    assert property (s_rd_take |=> s_axi_rvalid) else $error("read answer late");
  chk_rd_refuse:
    assert property (s_rd_take ##0 s_axi_araddr >= 8'h0C |=> s_axi_rresp == 2'h3)
      else $error("unmapped read not refused");
  chk_rd_single:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  chk_reset_idle:
    assert property ($rose(rst_n) |-> overtemp_alarm_out && !irq && !sda_oe)
      else $error("outputs not idle after reset");
  chk_sda_drain:
    assert property (sda_out == 1'b0) else $error("data pin driven high");
endmodule : tsa_chk

bind tsa_top tsa_chk #(.AW(AW)) u_tsa_chk (
  .mclk(mclk), .rst_n(rst_n), .sda_out(sda_out), .sda_oe(sda_oe),
  .overtemp_alarm_out(overtemp_alarm_out), .irq(irq),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid)
);

// [verification/tsa_i2c_mst.sv]
// Purpose: behavioural two-wire bus master facing the sensor block
// Assumes: wire level returns on sda_w; a released line is pulled up
// Notes:   bit cell 20 mclk (160 ns), 12 low then 8 high; clock rests high
`timescale 1ns/1ps
module tsa_i2c_mst (
  input  wire logic mclk,
  input  wire logic sda_w,
  output logic      scl      = 1'b1,
  output logic      sda_pull = 1'b0
);
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask : step

  // long low half: the slave drives late, so its data must settle before the rise
  task automatic bitx(input logic b, output logic s);
    step(4);
    sda_pull <= !b;
    step(8);
    scl <= 1'b1;
    step(8);
    s = sda_w;
    scl <= 1'b0;
  endtask : bitx

  // start or repeated start: data falls while the clock is high
  task automatic start();
    step(4);
    sda_pull <= 1'b0;
    step(8);
    scl <= 1'b1;
    step(8);
    sda_pull <= 1'b1;
    step(8);
    scl <= 1'b0;
  endtask : start

  // stop: data rises while the clock is high, then the bus rests
  task automatic stop();
    step(4);
    sda_pull <= 1'b1;
    step(8);
    scl <= 1'b1;
    step(8);
    sda_pull <= 1'b0;
    step(20);
  endtask : stop

  // byte out msb first, ninth cell samples the acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask : wbyte

  // byte in; nack high ends a read
  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, b[i]);
    bitx(nack, s);
  endtask : rbyte
endmodule : tsa_i2c_mst

// [verification/testbench.sv]
// Purpose: self-checking bench for the sensor alarm block
// Assumes: conversion shortened to 2000 mclk; converter code driven here
// Notes:   status over axi-lite, sensor registers over the serial model
`timescale 1ns/1ps
`include "tsa_consts.svh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] adc_code = 16'h1234;
  logic [1:0]  add_mode = 2'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, alarm, sda_oe, scl, sda_pull;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [15:0] w16;
  logic        ack;
  logic        spike = 1'b0;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  wire logic       sda_w = !(sda_pull || sda_oe);
  wire logic       add_in = spike | (add_mode[1] ? (add_mode[0] ? scl : sda_w) : add_mode[0]);
  wire logic [6:0] dev = {`TSA_I2C_BASE, add_mode};

  always #4 mclk = ~mclk;

  tsa_top #(.CONV_CYC(2000)) u_tsa_top (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
    .add_in(add_in), .adc_code(adc_code), .overtemp_alarm_out(alarm), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  tsa_i2c_mst u_tsa_i2c_mst (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_pull(sda_pull));

  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (20) @(posedge mclk);
  endtask : do_reset

  // each half held until its own ready edge; bready held until the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    @(posedge mclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    dv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  // irq carries conversion-done only; the status read clears it
  task automatic wait_conv();
    while (irq !== 1'b1)
      @(posedge mclk);
    axr(`TSA_AXI_IRQ_STATUS, d, r);
    chk(32'(d[`TSA_IRQ_CONV]), 32'h1);
    repeat (4) @(posedge mclk);
  endtask : wait_conv

  // pointer first, then nb data bytes msb first
  task automatic sw(input logic [6:0] ad, input logic [7:0] p, input int nb,
                    input logic [15:0] dv, output logic ok);
    logic a2;
    u_tsa_i2c_mst.start();
    u_tsa_i2c_mst.wbyte({ad, 1'b0}, ok);
    if (ok)
    begin
      u_tsa_i2c_mst.wbyte(p, a2);
      if (nb > 0)
        u_tsa_i2c_mst.wbyte(dv[15:8], a2);
      if (nb > 1)
        u_tsa_i2c_mst.wbyte(dv[7:0], a2);
    end
    u_tsa_i2c_mst.stop();
  endtask : sw

  // one-byte read lands in the upper half
  task automatic sr(input int nb, output logic [15:0] dv);
    logic a;
    dv = 16'h0;
    u_tsa_i2c_mst.start();
    u_tsa_i2c_mst.wbyte({dev, 1'b1}, a);
    u_tsa_i2c_mst.rbyte(dv[15:8], nb < 2);
    if (nb > 1)
      u_tsa_i2c_mst.rbyte(dv[7:0], 1'b1);
    u_tsa_i2c_mst.stop();
  endtask : sr

  initial
  begin
    // every strap: power-up word, own address acked, neighbour ignored
    for (int m = 0; m < 4; m++)
    begin
      add_mode <= 2'(m);
      do_reset();
      axr(`TSA_AXI_STATE, d, r);
      chk(32'(d[15:0]), 32'h8000);
      sw({`TSA_I2C_BASE, 2'(m + 1)}, 8'h00, 0, 16'h0, ack);
      chk(32'(ack), 32'h0);
      // a 40 ns spike on a low strap mid-transfer must not move the decode
      fork
        sw(dev, 8'h00, 0, 16'h0, ack);
        if (m == 0)
        begin
          repeat (100) @(posedge mclk);
          spike <= 1'b1;
          repeat (5) @(posedge mclk);
          spike <= 1'b0;
        end
      join
      chk(32'(ack), 32'h1);
      axr(`TSA_AXI_STATE, d, r);
      chk(32'(d[19:18]), 32'(m));
    end
    // mask reset and width, unmapped refusals
    axr(`TSA_AXI_IRQ_MASK, d, r);
    chk(d, 32'h0);
    axw(`TSA_AXI_IRQ_MASK, 32'hFF, r);
    axr(`TSA_AXI_IRQ_MASK, d, r);
    chk(d, 32'h7);
    axr(8'h0C, d, r);
    chk(32'(r), 32'(`TSA_AXI_DECERR));
    axw(8'h0C, 32'h1, r);
    chk(32'(r), 32'(`TSA_AXI_DECERR));
    axw(`TSA_AXI_IRQ_MASK, 32'h1, r);
    // reading is left aligned at 12 bits
    wait_conv();
    sw(dev, 8'h00, 0, 16'h0, ack);
    sr(2, w16);
    chk(32'(w16), 32'h1230);
    // the temperature read restarted the interval: no result for a while after stop
    axr(`TSA_AXI_IRQ_STATUS, d, r);
    repeat (1900) @(posedge mclk);
    axr(`TSA_AXI_IRQ_STATUS, d, r);
    chk(32'(d[`TSA_IRQ_CONV]), 32'h0);
    // upper pointer bits ignored, reserved config bits stored as zero
    sw(dev, 8'hFD, 1, 16'hEC00, ack);
    sr(1, w16);
    chk(32'(w16[15:8]), 32'h0C);
    chk(32'(alarm), 32'h0);
    sw(dev, 8'h03, 2, 16'h2000, ack);
    sw(dev, 8'h02, 2, 16'h1000, ack);
    sr(2, w16);
    chk(32'(w16), 32'h1000);
    // depth two: trip on the second hot result, release on the second cold one
    wait_conv();
    wait_conv();
    adc_code <= 16'h3000;
    wait_conv();
    chk(32'(alarm), 32'h0);
    wait_conv();
    chk(32'(alarm), 32'h1);
    adc_code <= 16'h1800;
    wait_conv();
    wait_conv();
    chk(32'(alarm), 32'h1);
    adc_code <= 16'h0800;
    wait_conv();
    chk(32'(alarm), 32'h1);
    wait_conv();
    chk(32'(alarm), 32'h0);
    // interrupt mode: a read clears, the next hot result sets again
    adc_code <= 16'h3000;
    sw(dev, 8'h01, 1, 16'h0600, ack);
    wait_conv();
    wait_conv();
    chk(32'(alarm), 32'h1);
    sr(1, w16);
    chk(32'(alarm), 32'h0);
    wait_conv();
    chk(32'(alarm), 32'h1);
    sw(dev, 8'h01, 1, 16'h0200, ack);
    chk(32'(alarm), 32'h0);
    // shutdown: result parked, no conversions, serial port alive
    sw(dev, 8'h01, 1, 16'h0100, ack);
    axr(`TSA_AXI_STATE, d, r);
    chk(32'(d[15:0]), 32'h8000);
    axr(`TSA_AXI_IRQ_STATUS, d, r);
    repeat (2500) @(posedge mclk);
    axr(`TSA_AXI_IRQ_STATUS, d, r);
    chk(32'(d[`TSA_IRQ_CONV]), 32'h0);
    sr(1, w16);
    chk(32'(w16[15:8]), 32'h01);
    report_and_stop();
  end

  // hang guard, about 2.4 times the expected run
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
endmodule : testbench
